// file: common/smc_pkg.sv
package smc_pkg;
    // register index on the device's internal register port
    localparam logic [5:0] SMC_CFG_IDX = 6'h1a;
    localparam int SMC_REG_W = 24;
    localparam int SMC_ADDR_W = 6;
    // field positions inside the configuration word
    localparam int SMC_SUPPLY_DIV_BIT = 23;
    localparam int SMC_SELFTEST_BIT = 22;
    localparam int SMC_WET_DIAG_HI = 21;
    localparam int SMC_WET_DIAG_LO = 18;
    localparam int SMC_SUPPLY_MEAS_BIT = 17;
    localparam int SMC_TW_SRC_DIS_BIT = 16;
    localparam int SMC_FILTER_HI = 15;
    localparam int SMC_FILTER_LO = 14;
    localparam int SMC_TW_SNK_DIS_BIT = 13;
    localparam int SMC_INT_SCHEME_BIT = 12;
    localparam int SMC_UPPER_LO = 12;
    localparam int SMC_UPPER_W = 12;
    localparam logic [11:0] SMC_UPPER_RST = 12'h000;
    // supply measurement division factors
    localparam logic [3:0] SMC_DIV_LOW = 4'h3;
    localparam logic [3:0] SMC_DIV_HIGH = 4'ha;
    localparam logic [3:0] SMC_DIV_RST = 4'h3;
    // consecutive-sample counter width
    localparam int SMC_CNT_W = 3;
endpackage

// file: verilog/smc_config_upper.sv
`timescale 1ns/10ps
// How it works
// - divider select bit picks supply division factor 3 when clear, 10 when set
// - bit 22 switches the converter self-diagnostic off (0) or on (1)
// - bits 21..18 enable wetting diagnostics for inputs 3..0 individually
// - bit 17 set requests supply measurement at each polling cycle end
// - bit 16 clear lets thermal warning cut high source inputs to 2 mA
// - bit 13 clear lets thermal warning cut high sink inputs to 2 mA
// - filter field needs 1, 2, 3 or 4 equal consecutive samples
// - bit 12 chooses static (0) or dynamic (1) interrupt pin assertion
module smc_config_upper
    import smc_pkg::*;
#(
    parameter int NUM_IN = 24
) (
    input wire logic clk, // 200 MHz device clock
    input wire logic arst_n, // asynchronous reset, active low
    input wire logic regWrite, // one-cycle register write strobe
    input wire logic regRead, // one-cycle register read strobe
    input wire logic [SMC_ADDR_W-1:0] regAddr, // register index
    input wire logic [SMC_REG_W-1:0] regWdata, // write data
    output logic [SMC_REG_W-1:0] regRdata, // read data, held
    output logic regRvalid, // read data valid pulse
    output logic [3:0] supplyDivFactor, // supply division factor
    output logic converterSelftestEnable, // converter self-diagnostic on
    output logic [3:0] wettingDiagEnable, // wetting diagnostic per input 3..0
    input wire logic pollCycleEnd, // pulse at end of each polling cycle
    output logic supplyMeasureStart, // pulse: take a supply measurement
    input wire logic thermalWarning, // thermal warning level
    input wire logic [NUM_IN-1:0] sourceHighSetting, // source at 10/15 mA
    input wire logic [NUM_IN-1:0] currentSinkHighSetting, // sink at 10/15 mA
    output logic [NUM_IN-1:0] sourceReduce, // cut source current to 2 mA
    output logic [NUM_IN-1:0] sinkReduce, // cut sink current to 2 mA
    input wire logic sampleStrobe, // pulse: new detection sample
    input wire logic [NUM_IN-1:0] sampleData, // raw detection samples
    output logic [NUM_IN-1:0] filteredData, // samples accepted as valid
    output logic filteredStrobe, // pulse: filteredData updated
    output logic interruptDynamic // interrupt pin scheme, 1 = dynamic
);

    initial begin
        if (NUM_IN < 4 || NUM_IN > 64) begin
            $error("NUM_IN must lie between 4 and 64");
        end
        // the run counter must reach the deepest filter setting
        if ((1 << SMC_CNT_W) - 1 < 4) begin
            $error("SMC_CNT_W too small for the filter depth");
        end
        // the stored field must end at the top of the word
        if (SMC_UPPER_LO + SMC_UPPER_W != SMC_REG_W) begin
            $error("upper field does not reach the top of the word");
        end
    end

    typedef struct packed {
        logic [SMC_UPPER_W-1:0] cfg;
        logic [SMC_REG_W-1:0] rdata;
        logic rvalid;
        logic [3:0] divFactor;
        logic measStart;
        logic [NUM_IN-1:0] srcRed;
        logic [NUM_IN-1:0] snkRed;
        logic [NUM_IN-1:0] lastSample;
        logic [NUM_IN-1:0][SMC_CNT_W-1:0] runLen;
        logic [NUM_IN-1:0] filtered;
        logic filtStb;
    } smc_state_t;

    localparam smc_state_t SMC_STATE_RST = '{
        cfg: SMC_UPPER_RST,
        rdata: '0,
        rvalid: 1'b0,
        divFactor: SMC_DIV_RST,
        measStart: 1'b0,
        srcRed: '0,
        snkRed: '0,
        lastSample: '0,
        runLen: '0,
        filtered: '0,
        filtStb: 1'b0
    };

    smc_state_t state_q;
    smc_state_t state_d;

    // word-level view of the configuration field bits
    function automatic logic cfgBit(input logic [SMC_UPPER_W-1:0] c,
                                    input int pos);
        cfgBit = c[pos-SMC_UPPER_LO];
    endfunction

    // the only register index that writes reach and reads return data from
    function automatic logic cfgHit(input logic [SMC_ADDR_W-1:0] a);
        cfgHit = (a == SMC_CFG_IDX);
    endfunction

    // run length of equal samples, saturating at the needed depth;
    // a zero run marks an input that has seen no sample yet
    function automatic logic [SMC_CNT_W-1:0] nextRun(
        input logic now,
        input logic last,
        input logic [SMC_CNT_W-1:0] run,
        input logic [SMC_CNT_W-1:0] need
    );
        if (now != last || run == '0) begin
            nextRun = SMC_CNT_W'(1);
        end else if (run < need) begin
            nextRun = run + SMC_CNT_W'(1);
        end else begin
            nextRun = run;
        end
    endfunction

    logic [1:0] filtSel;
    logic [SMC_CNT_W-1:0] needLen;

    always_comb begin
        state_d = state_q;
        state_d.rvalid = 1'b0;
        state_d.measStart = 1'b0;
        state_d.filtStb = 1'b0;

        if (regWrite && cfgHit(regAddr)) begin
            state_d.cfg = regWdata[SMC_REG_W-1:SMC_UPPER_LO];
        end
        // a read answers every index; unknown ones read zero
        if (regRead) begin
            state_d.rvalid = 1'b1;
            if (cfgHit(regAddr)) begin
                state_d.rdata = {state_q.cfg, {SMC_UPPER_LO{1'b0}}};
            end else begin
                state_d.rdata = '0;
            end
        end

        if (cfgBit(state_q.cfg, SMC_SUPPLY_DIV_BIT)) begin
            state_d.divFactor = SMC_DIV_HIGH;
        end else begin
            state_d.divFactor = SMC_DIV_LOW;
        end

        if (pollCycleEnd && cfgBit(state_q.cfg, SMC_SUPPLY_MEAS_BIT)) begin
            state_d.measStart = 1'b1;
        end else begin
            state_d.measStart = 1'b0;
        end

        if (thermalWarning && !cfgBit(state_q.cfg, SMC_TW_SRC_DIS_BIT)) begin
            state_d.srcRed = sourceHighSetting;
        end else begin
            state_d.srcRed = '0;
        end

        if (thermalWarning && !cfgBit(state_q.cfg, SMC_TW_SNK_DIS_BIT)) begin
            state_d.snkRed = currentSinkHighSetting;
        end else begin
            state_d.snkRed = '0;
        end

        // consecutive equal sample filter
        // history survives field changes; the host stops polling first
        filtSel = state_q.cfg[SMC_FILTER_HI-SMC_UPPER_LO:
                              SMC_FILTER_LO-SMC_UPPER_LO];
        needLen = SMC_CNT_W'(filtSel) + SMC_CNT_W'(1);
        if (sampleStrobe) begin
            state_d.filtStb = 1'b1;
            state_d.lastSample = sampleData;
            for (int i = 0; i < NUM_IN; i++) begin
                state_d.runLen[i] = nextRun(sampleData[i],
                                            state_q.lastSample[i],
                                            state_q.runLen[i], needLen);
                if (state_d.runLen[i] >= needLen) begin
                    state_d.filtered[i] = sampleData[i];
                end
            end
        end
    end

    // every output below is a field of this one register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= SMC_STATE_RST;
        end else begin
            state_q <= state_d;
        end
    end


    // register port answer
    assign regRdata = state_q.rdata;
    assign regRvalid = state_q.rvalid;

    // configuration levels
    assign supplyDivFactor = state_q.divFactor;
    assign converterSelftestEnable = state_q.cfg[SMC_SELFTEST_BIT-SMC_UPPER_LO];
    assign wettingDiagEnable = state_q.cfg[SMC_WET_DIAG_HI-SMC_UPPER_LO:
                                           SMC_WET_DIAG_LO-SMC_UPPER_LO];

    // measurement, current reduction, filter results and interrupt scheme
    assign supplyMeasureStart = state_q.measStart;
    assign sourceReduce = state_q.srcRed;
    assign sinkReduce = state_q.snkRed;
    assign filteredData = state_q.filtered;
    assign filteredStrobe = state_q.filtStb;
    assign interruptDynamic = state_q.cfg[SMC_INT_SCHEME_BIT-SMC_UPPER_LO];

endmodule

// file: dv/smc_config_upper_props.sv
`timescale 1ns/10ps
module smc_config_upper_props
    import smc_pkg::*;
(
    input wire logic clk, arst_n, regWrite, regRead, regRvalid,
    input wire logic [SMC_ADDR_W-1:0] regAddr,
    input wire logic [SMC_REG_W-1:0] regWdata,
    input wire logic [3:0] supplyDivFactor, wettingDiagEnable,
    input wire logic converterSelftestEnable, interruptDynamic,
    input wire logic pollCycleEnd, supplyMeasureStart,
    input wire logic sampleStrobe, filteredStrobe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_wr;
        regWrite && regAddr == SMC_CFG_IDX;
    endsequence
    a_read_answer: assert property (regRead |=> regRvalid)
        else $error("read unanswered");
    a_answer_cause: assert property (regRvalid |-> $past(regRead))
        else $error("stray answer");
    a_selftest_bit: assert property (s_wr |=>
        converterSelftestEnable == $past(regWdata[22])) else $error("selftest");
    a_wet_diag: assert property (s_wr |=>
        wettingDiagEnable == $past(regWdata[21:18])) else $error("wet diag");
    a_int_scheme: assert property (s_wr |=>
        interruptDynamic == $past(regWdata[12])) else $error("int scheme");
    a_divider_pick: assert property (s_wr ##1 !regWrite |=>
        supplyDivFactor == ($past(regWdata[23], 2) ? 4'ha : 4'h3))
        else $error("divider");
    a_measure_cause: assert property (supplyMeasureStart |->
        $past(pollCycleEnd)) else $error("stray measure");
    a_filter_strobe: assert property (sampleStrobe |=> filteredStrobe)
        else $error("no filter strobe");
endmodule
bind smc_config_upper smc_config_upper_props i_props (.*);

// file: dv/smc_host_model.sv
`timescale 1ns/10ps
module smc_host_model
    import smc_pkg::*;
(
    input wire logic clk, // device clock
    input wire logic [SMC_REG_W-1:0] regRdata, // read data
    output logic regWrite = 1'b0, // write strobe
    output logic regRead = 1'b0, // read strobe
    output logic [SMC_ADDR_W-1:0] regAddr = 6'h00, // index
    output logic [SMC_REG_W-1:0] regWdata = 24'h000000 // write data
);
    // reconfigure while idle: callers write only with inputs at rest
    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
        regWdata <= ~d;
    endtask
    task automatic rd(input logic [5:0] a, output logic [23:0] d);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        d = regRdata;
    endtask
endmodule

// file: dv/smc_config_upper_test.sv
`timescale 1ns/10ps
module smc_config_upper_test
    import smc_pkg::*;
;
    logic clk = 1'b0, arst_n = 1'b0, regWrite, regRead, regRvalid;
    logic pollCycleEnd = 1'b0, thermalWarning = 1'b1, sampleStrobe = 1'b0;
    logic converterSelftestEnable, supplyMeasureStart, filteredStrobe;
    logic interruptDynamic;
    logic [5:0] regAddr;
    logic [3:0] supplyDivFactor, wettingDiagEnable;
    logic [23:0] regWdata, regRdata, rd, sourceReduce, sinkReduce, filteredData;
    logic [23:0] sampleData = 24'h0, sourceHighSetting = 24'h0f0f0f;
    logic [23:0] currentSinkHighSetting = 24'h00ffff;
    logic [23:0] pat [3] = '{24'hffffff, 24'h555555, 24'haaa000};
    int miscompares = 0, comparisons = 0, cycles = 0;
    always #2.5 clk = ~clk;
    smc_host_model i_host (.*);
    smc_config_upper i_dut (.*);
    task automatic chk(input string n, input logic [23:0] s, e);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        i_host.rd(SMC_CFG_IDX, rd);
        chk("cfg", rd, 24'h0);
        chk("rvalid", 24'(regRvalid), 24'h1);
        chk("div", 24'(supplyDivFactor), 24'h3);
        foreach (pat[i]) begin
            i_host.wr(SMC_CFG_IDX, pat[i]);
            i_host.rd(SMC_CFG_IDX, rd);
            chk("cfg", rd, pat[i] & 24'hfff000);
            chk("div", 24'(supplyDivFactor), pat[i][23] ? 24'ha : 24'h3);
            chk("flags", 24'({converterSelftestEnable, wettingDiagEnable,
                interruptDynamic}), 24'({pat[i][22:18], pat[i][12]}));
        end
        i_host.wr(6'h1b, 24'hffffff);
        i_host.rd(SMC_CFG_IDX, rd);
        chk("kept", rd, 24'haaa000);
        i_host.rd(6'h1b, rd);
        chk("unmapped", rd, 24'h0);
        for (int t = 0; t < 4; t++) begin
            i_host.wr(SMC_CFG_IDX, {6'h0, t[0], t[1], 2'h0, t[0], 13'h0});
            @(posedge clk);
            pollCycleEnd <= 1'b1;
            @(posedge clk);
            pollCycleEnd <= 1'b0;
            #1;
            chk("measure", 24'(supplyMeasureStart), 24'(t[0]));
            chk("src", sourceReduce, t[1] ? 24'h0 : sourceHighSetting);
            chk("snk", sinkReduce, t[0] ? 24'h0 : currentSinkHighSetting);
        end
        for (int f = 0; f < 4; f++) begin
            i_host.wr(SMC_CFG_IDX, 24'(f) << 14);
            @(posedge clk);
            sampleStrobe <= 1'b1;
            sampleData <= f[0] ? 24'h0 : 24'hffffff;
            repeat (f) @(posedge clk);
            #1;
            chk("early", filteredData, f[0] ? 24'hffffff : 24'h0);
            @(posedge clk);
            sampleStrobe <= 1'b0;
            #1;
            chk("filter", filteredData, f[0] ? 24'h0 : 24'hffffff);
            chk("fstrobe", 24'(filteredStrobe), 24'h1);
        end
        tally_and_finish();
    end
endmodule
